// File: hw/iprr_map.svh
// Offsets, field positions, masks and reset values of the priority register pair
// Function
// RL1 - Field value 00 disables its source; it never raises a request.
// RL2 - Field values 01, 10, 11 select priority levels 0, 1, 2.
// RL3 - Every covered source is limited to levels 0 through 2.
// RL4 - Reset clears all fields, so every covered source starts disabled.
// RL5 - Bits 11-10 of the first register read zero and ignore writes.
// RL6 - First priority register sits at offset 8.
// RL7 - Second priority register sits at offset 9.
// RL8 - First register bits 15-14: serial 0 receiver full level.
// RL9 - First register bits 13-12: serial 0 receiver error level.
// RL10 - First register bits 9-8: serial 0 transmitter idle level.
// RL11 - First register bits 7-6: serial 0 transmitter empty level.
// RL12 - First register bits 5-4, 3-2, 1-0: timer A channels 3, 2, 1.
// RL13 - Second register bits 15-14, 13-12: PWM A and B fault levels.
// RL14 - Second register bits 11-10, 9-8: PWM A and B reload levels.
// RL15 - Second register bits 7-6, 5-4: ADC A and B zero-cross levels.
// RL16 - Second register bits 3-2: ADC A conversion complete level.
// RL17 - Second register bits 1-0: ADC B conversion complete level.
// RL18 - A written level is readable and effective the cycle after the write.
`ifndef IPRR_MAP_SVH
`define IPRR_MAP_SVH

`define IPRR_ADDR_W 4
`define IPRR_OFS_SER_TMR 4'h8
`define IPRR_OFS_PWM_ADC 4'h9
`define IPRR_RST_VAL 16'h0000
`define IPRR_WMASK_SER_TMR 16'hF3FF
`define IPRR_WMASK_PWM_ADC 16'hFFFF
`define IPRR_SRC_N 15

`define IPRR_POS_S0_RX_FULL 14
`define IPRR_POS_S0_RX_ERR 12
`define IPRR_POS_S0_TX_IDLE 8
`define IPRR_POS_S0_TX_EMPTY 6
`define IPRR_POS_TA_CH3 4
`define IPRR_POS_TA_CH2 2
`define IPRR_POS_TA_CH1 0
`define IPRR_POS_PWMA_FAULT 14
`define IPRR_POS_PWMB_FAULT 12
`define IPRR_POS_PWMA_RELOAD 10
`define IPRR_POS_PWMB_RELOAD 8
`define IPRR_POS_ADCA_ZC 6
`define IPRR_POS_ADCB_ZC 4
`define IPRR_POS_ADCA_CC 2
`define IPRR_POS_ADCB_CC 0

`endif

// File: hw/iprr_pkg.sv
// Types shared by the priority register pair
`include "iprr_map.svh"
package iprr_pkg;
  typedef logic [15:0] iprr_word_t;

  typedef struct packed {
    logic [`IPRR_ADDR_W-1:0] addr;
    iprr_word_t wdata;
    logic wr;
    logic rd;
  } iprr_bus_s;

  // Enable plus level 0..2 for one source
  typedef struct packed {
    logic en;
    logic [1:0] lvl;
  } iprr_src_s;

  typedef enum {
    SRC_S0_RX_FULL, SRC_S0_RX_ERR, SRC_S0_TX_IDLE, SRC_S0_TX_EMPTY,
    SRC_TA_CH3, SRC_TA_CH2, SRC_TA_CH1,
    SRC_PWMA_FAULT, SRC_PWMB_FAULT, SRC_PWMA_RELOAD, SRC_PWMB_RELOAD,
    SRC_ADCA_ZC, SRC_ADCB_ZC, SRC_ADCA_CC, SRC_ADCB_CC
  } iprr_src_e;
endpackage

// File: hw/iprr_prio_reg.sv
// One 16-bit priority register with a write mask
`timescale 1ns/1ps
`include "iprr_map.svh"
module iprr_prio_reg #(
  parameter logic [`IPRR_ADDR_W-1:0] REG_OFS = `IPRR_OFS_SER_TMR,
  parameter logic [15:0] WMASK = 16'hFFFF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire iprr_pkg::iprr_bus_s bus,
  // Stored and next value
  output iprr_pkg::iprr_word_t regQ,
  output iprr_pkg::iprr_word_t regNxt
);
  import iprr_pkg::*;

  iprr_word_t val_r;
  iprr_word_t val_nxt;

  always_comb begin
    val_nxt = val_r;
    // RL5 masked bits kept
    if (bus.wr && bus.addr == REG_OFS) begin
      val_nxt = (val_r & ~WMASK) | (bus.wdata & WMASK);
    end
  end

  always_ff @(posedge clk) begin
    // RL4 cleared on reset
    if (!rstn) begin
      val_r <= `IPRR_RST_VAL;
    end else begin
      val_r <= val_nxt;
    end
  end

  assign regQ = val_r;
  assign regNxt = val_nxt;
endmodule

// File: hw/iprr_field_dec.sv
// Splits the two priority words into per-source enable and level
`timescale 1ns/1ps
`include "iprr_map.svh"
module iprr_field_dec (
  // Register words
  input wire iprr_pkg::iprr_word_t serTmr,
  input wire iprr_pkg::iprr_word_t pwmAdc,
  // Decoded sources
  output iprr_pkg::iprr_src_s [`IPRR_SRC_N-1:0] srcCfg
);
  import iprr_pkg::*;

  // RL2 RL3 field to level map
  function automatic iprr_src_s lvlDec(input logic [1:0] f);
    iprr_src_s s;
    s.en = (f != 2'h0);
    s.lvl = s.en ? 2'(f - 2'h1) : 2'h0;
    return s;
  endfunction

  always_comb begin
    // RL8 RL9 serial 0 receive
    srcCfg[SRC_S0_RX_FULL] = lvlDec(serTmr[`IPRR_POS_S0_RX_FULL +: 2]);
    srcCfg[SRC_S0_RX_ERR] = lvlDec(serTmr[`IPRR_POS_S0_RX_ERR +: 2]);
    // RL10 RL11 serial 0 transmit
    srcCfg[SRC_S0_TX_IDLE] = lvlDec(serTmr[`IPRR_POS_S0_TX_IDLE +: 2]);
    srcCfg[SRC_S0_TX_EMPTY] = lvlDec(serTmr[`IPRR_POS_S0_TX_EMPTY +: 2]);
    // RL12 timer A channels
    srcCfg[SRC_TA_CH3] = lvlDec(serTmr[`IPRR_POS_TA_CH3 +: 2]);
    srcCfg[SRC_TA_CH2] = lvlDec(serTmr[`IPRR_POS_TA_CH2 +: 2]);
    srcCfg[SRC_TA_CH1] = lvlDec(serTmr[`IPRR_POS_TA_CH1 +: 2]);
    // RL13 RL14 PWM faults and reloads
    srcCfg[SRC_PWMA_FAULT] = lvlDec(pwmAdc[`IPRR_POS_PWMA_FAULT +: 2]);
    srcCfg[SRC_PWMB_FAULT] = lvlDec(pwmAdc[`IPRR_POS_PWMB_FAULT +: 2]);
    srcCfg[SRC_PWMA_RELOAD] = lvlDec(pwmAdc[`IPRR_POS_PWMA_RELOAD +: 2]);
    srcCfg[SRC_PWMB_RELOAD] = lvlDec(pwmAdc[`IPRR_POS_PWMB_RELOAD +: 2]);
    // RL15 RL16 RL17 ADC events
    srcCfg[SRC_ADCA_ZC] = lvlDec(pwmAdc[`IPRR_POS_ADCA_ZC +: 2]);
    srcCfg[SRC_ADCB_ZC] = lvlDec(pwmAdc[`IPRR_POS_ADCB_ZC +: 2]);
    srcCfg[SRC_ADCA_CC] = lvlDec(pwmAdc[`IPRR_POS_ADCA_CC +: 2]);
    srcCfg[SRC_ADCB_CC] = lvlDec(pwmAdc[`IPRR_POS_ADCB_CC +: 2]);
  end
endmodule

// File: hw/iprr_top.sv
// Priority register pair with readback, level outputs and request gating
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "iprr_map.svh"
module iprr_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire iprr_pkg::iprr_bus_s bus,
  output iprr_pkg::iprr_word_t rdata,
  // Raw source events, same clock
  input wire logic [`IPRR_SRC_N-1:0] srcIrq,
  // To arbitration
  output iprr_pkg::iprr_src_s [`IPRR_SRC_N-1:0] srcLevel,
  output logic [`IPRR_SRC_N-1:0] srcReq
);
  import iprr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers

  iprr_word_t serTmrQ;
  iprr_word_t serTmrNxt;
  iprr_word_t pwmAdcQ;
  iprr_word_t pwmAdcNxt;

  // RL6 first register
  iprr_prio_reg #(
    .REG_OFS(`IPRR_OFS_SER_TMR),
    .WMASK(`IPRR_WMASK_SER_TMR)
  ) uSerTmr (
    .clk(clk),
    .rstn(rstn),
    .bus(bus),
    .regQ(serTmrQ),
    .regNxt(serTmrNxt)
  );

  // RL7 second register
  iprr_prio_reg #(
    .REG_OFS(`IPRR_OFS_PWM_ADC),
    .WMASK(`IPRR_WMASK_PWM_ADC)
  ) uPwmAdc (
    .clk(clk),
    .rstn(rstn),
    .bus(bus),
    .regQ(pwmAdcQ),
    .regNxt(pwmAdcNxt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Field decode

  iprr_src_s [`IPRR_SRC_N-1:0] cfgNxt;

  // RL18 decode from next value
  iprr_field_dec uDec (
    .serTmr(serTmrNxt),
    .pwmAdc(pwmAdcNxt),
    .srcCfg(cfgNxt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read port

  iprr_word_t rdata_r;
  iprr_word_t rdata_nxt;

  always_comb begin
    rdata_nxt = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        // RL5 reserved bits read zero
        `IPRR_OFS_SER_TMR: begin
          rdata_nxt = serTmrQ & `IPRR_WMASK_SER_TMR;
        end
        `IPRR_OFS_PWM_ADC: begin
          rdata_nxt = pwmAdcQ;
        end
        default: begin
          rdata_nxt = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // Level and request outputs

  iprr_src_s [`IPRR_SRC_N-1:0] level_r;
  logic [`IPRR_SRC_N-1:0] req_r;
  logic [`IPRR_SRC_N-1:0] req_nxt;
  logic [`IPRR_SRC_N-1:0] enNxt;

  always_comb begin
    for (int i = 0; i < `IPRR_SRC_N; i++) begin
      enNxt[i] = cfgNxt[i].en;
    end
    // RL1 disabled sources gated
    req_nxt = srcIrq & enNxt;
  end

  always_ff @(posedge clk) begin
    // RL4 all disabled after reset
    if (!rstn) begin
      level_r <= '0;
      req_r <= '0;
    end else begin
      level_r <= cfgNxt;
      req_r <= req_nxt;
    end
  end

  assign srcLevel = level_r;
  assign srcReq = req_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic [`IPRR_SRC_N-1:0] enNow;
  logic lvlOver;
  logic lvlStray;

  always_comb begin
    lvlOver = 1'b0;
    lvlStray = 1'b0;
    for (int i = 0; i < `IPRR_SRC_N; i++) begin
      enNow[i] = level_r[i].en;
      if (level_r[i].lvl > 2'h2) begin
        lvlOver = 1'b1;
      end
      if (!level_r[i].en && level_r[i].lvl != 2'h0) begin
        lvlStray = 1'b1;
      end
    end
  end

  logic wrSer;
  logic wrPwm;
  logic rdSer;
  logic rdPwm;

  assign wrSer = bus.wr && bus.addr == `IPRR_OFS_SER_TMR;
  assign wrPwm = bus.wr && bus.addr == `IPRR_OFS_PWM_ADC;
  assign rdSer = bus.rd && bus.addr == `IPRR_OFS_SER_TMR;
  assign rdPwm = bus.rd && bus.addr == `IPRR_OFS_PWM_ADC;

  no_req_disabled_a: assert property ( // RL1
    (req_r & ~enNow) == '0
  ) else $error("request raised by a disabled source");

  field_off_a: assert property ( // RL1
    wrSer && bus.wdata[15:14] == 2'h0
    |=> !srcLevel[SRC_S0_RX_FULL].en && !srcReq[SRC_S0_RX_FULL]
  ) else $error("zero field did not disable the source");

  level_map_a: assert property ( // RL2
    wrPwm && bus.wdata[11:10] != 2'h0
    |=> srcLevel[SRC_PWMA_RELOAD].en
        && srcLevel[SRC_PWMA_RELOAD].lvl == 2'($past(bus.wdata[11:10]) - 2'h1)
  ) else $error("field value mapped to the wrong level");

  level_range_a: assert property ( // RL3
    !lvlOver
  ) else $error("level above two reported");

  reset_clear_a: assert property ( // RL4
    disable iff (1'b0)
    !rstn |=> serTmrQ == 16'h0000 && pwmAdcQ == 16'h0000 && srcLevel == '0 && srcReq == '0
  ) else $error("reset left a field set");

  rsvd_zero_a: assert property ( // RL5
    rdSer |=> rdata[11:10] == 2'h0
  ) else $error("reserved bits read nonzero");

  ser_readback_a: assert property ( // RL6
    wrSer ##1 rdSer && !bus.wr
    |=> rdata == ($past(bus.wdata, 2) & `IPRR_WMASK_SER_TMR)
  ) else $error("first register readback mismatch");

  adcb_cc_map_a: assert property ( // RL17
    wrPwm |=> srcLevel[SRC_ADCB_CC].en == ($past(bus.wdata[1:0]) != 2'h0)
  ) else $error("second register low field misplaced");

  timer_map_a: assert property ( // RL12
    wrSer |=> srcLevel[SRC_TA_CH3].en == ($past(bus.wdata[5:4]) != 2'h0)
              && srcLevel[SRC_TA_CH1].en == ($past(bus.wdata[1:0]) != 2'h0)
  ) else $error("timer field misplaced");

  tx_empty_map_a: assert property ( // RL11
    wrSer |=> srcLevel[SRC_S0_TX_EMPTY].en == ($past(bus.wdata[7:6]) != 2'h0)
  ) else $error("transmit empty field misplaced");

  pwm_fault_map_a: assert property ( // RL13
    wrPwm |=> srcLevel[SRC_PWMB_FAULT].en == ($past(bus.wdata[13:12]) != 2'h0)
  ) else $error("fault field misplaced");

  write_effect_a: assert property ( // RL18
    wrSer && bus.wdata[9:8] == 2'h3 && srcIrq[SRC_S0_TX_IDLE]
    |=> srcReq[SRC_S0_TX_IDLE] && srcLevel[SRC_S0_TX_IDLE].lvl == 2'h2
  ) else $error("write not effective the next cycle");

  idle_rdata_a: assert property ( // RL18
    !bus.rd |=> rdata == 16'h0000
  ) else $error("read data outside the answer cycle");

  pwm_readback_a: assert property ( // RL7
    wrPwm ##1 rdPwm && !bus.wr
    |=> rdata == $past(bus.wdata, 2)
  ) else $error("second register readback mismatch");

  rx_full_map_a: assert property ( // RL8
    wrSer |=> srcLevel[SRC_S0_RX_FULL].en == ($past(bus.wdata[15:14]) != 2'h0)
  ) else $error("receive full field misplaced");

  rx_error_map_a: assert property ( // RL9
    wrSer |=> srcLevel[SRC_S0_RX_ERR].en == ($past(bus.wdata[13:12]) != 2'h0)
  ) else $error("receive error field misplaced");

  tx_idle_map_a: assert property ( // RL10
    wrSer |=> srcLevel[SRC_S0_TX_IDLE].en == ($past(bus.wdata[9:8]) != 2'h0)
  ) else $error("transmit idle field misplaced");

  timer_mid_map_a: assert property ( // RL12
    wrSer |=> srcLevel[SRC_TA_CH2].en == ($past(bus.wdata[3:2]) != 2'h0)
  ) else $error("timer channel 2 field misplaced");

  pwma_fault_map_a: assert property ( // RL13
    wrPwm |=> srcLevel[SRC_PWMA_FAULT].en == ($past(bus.wdata[15:14]) != 2'h0)
  ) else $error("PWM A fault field misplaced");

  reload_map_a: assert property ( // RL14
    wrPwm |=> srcLevel[SRC_PWMA_RELOAD].en == ($past(bus.wdata[11:10]) != 2'h0)
              && srcLevel[SRC_PWMB_RELOAD].en == ($past(bus.wdata[9:8]) != 2'h0)
  ) else $error("reload field misplaced");

  zero_cross_map_a: assert property ( // RL15
    wrPwm |=> srcLevel[SRC_ADCA_ZC].en == ($past(bus.wdata[7:6]) != 2'h0)
              && srcLevel[SRC_ADCB_ZC].en == ($past(bus.wdata[5:4]) != 2'h0)
  ) else $error("zero crossing field misplaced");

  adca_done_map_a: assert property ( // RL16
    wrPwm |=> srcLevel[SRC_ADCA_CC].en == ($past(bus.wdata[3:2]) != 2'h0)
  ) else $error("conversion complete field misplaced");

  rsvd_hold_a: assert property ( // RL5
    wrSer |=> serTmrQ[11:10] == 2'h0
  ) else $error("reserved bits stored");

  ser_hold_a: assert property ( // RL6
    !wrSer |=> serTmrQ == $past(serTmrQ)
  ) else $error("first register changed without a write");

  pwm_hold_a: assert property ( // RL7
    !wrPwm |=> pwmAdcQ == $past(pwmAdcQ)
  ) else $error("second register changed without a write");

  req_follow_a: assert property ( // RL1
    srcReq == ($past(srcIrq) & enNow)
  ) else $error("request does not follow event and enable");

  rx_full_level_a: assert property ( // RL2
    wrSer && bus.wdata[15:14] != 2'h0
    |=> srcLevel[SRC_S0_RX_FULL].lvl == 2'($past(bus.wdata[15:14]) - 2'h1)
  ) else $error("receive full level mapped wrong");

  pwm_off_a: assert property ( // RL1
    wrPwm && bus.wdata[1:0] == 2'h0
    |=> !srcLevel[SRC_ADCB_CC].en && !srcReq[SRC_ADCB_CC]
  ) else $error("zero field left the source enabled");

  off_level_zero_a: assert property ( // RL1
    !lvlStray
  ) else $error("disabled source reports a level");

  cover_top_level_c: cover property (
    wrPwm && bus.wdata[15:14] == 2'h3 ##1 srcLevel[SRC_PWMA_FAULT].lvl == 2'h2
  );

  cover_readback_c: cover property (
    wrSer ##1 rdSer ##1 rdata != 16'h0000
  );

  cover_gated_c: cover property (
    srcIrq[SRC_ADCA_CC] && !cfgNxt[SRC_ADCA_CC].en ##1 !srcReq[SRC_ADCA_CC]
  );

  cover_event_gone_c: cover property (
    srcReq[SRC_TA_CH1] ##1 !srcReq[SRC_TA_CH1] && srcLevel[SRC_TA_CH1].en
  );

  cover_pwm_readback_c: cover property (
    wrPwm ##1 rdPwm ##1 rdata == 16'hFFFF
  );
endmodule

// File: dv/iprr_arb_model.sv
// Arbiter stand-in: feeds source events and picks the top requester
`timescale 1ns/1ps
`include "iprr_map.svh"
module iprr_arb_model (
  // Clock
  clk,
  // Event pattern and raw events
  evt,
  srcIrq,
  // From the priority block
  srcLevel,
  srcReq,
  // Winning source
  winIdx
);
  import iprr_pkg::*;
  input wire logic clk;
  input wire logic [`IPRR_SRC_N-1:0] evt;
  output logic [`IPRR_SRC_N-1:0] srcIrq;
  input wire iprr_src_s [`IPRR_SRC_N-1:0] srcLevel;
  input wire logic [`IPRR_SRC_N-1:0] srcReq;
  output logic [3:0] winIdx;
  logic found;
  initial srcIrq = '0;
  always @(posedge clk) begin
    srcIrq <= evt;
  end
  // Highest level wins, lowest index on a tie
  always_comb begin
    found = 1'b0;
    winIdx = 4'h0;
    for (int i = `IPRR_SRC_N - 1; i >= 0; i--) begin
      if (srcReq[i] && srcLevel[i].en && (!found || srcLevel[i].lvl >= srcLevel[winIdx].lvl)) begin
        found = 1'b1;
        winIdx = 4'(i);
      end
    end
  end
endmodule

// File: dv/iprr_top_tb.sv
// Self-checking bench for the priority register pair
`timescale 1ns/1ps
`include "iprr_map.svh"
module iprr_top_tb;
  import iprr_pkg::*;
  logic clk;
  logic rstn;
  iprr_bus_s bus;
  iprr_word_t rdata;
  logic [`IPRR_SRC_N-1:0] srcIrq;
  logic [`IPRR_SRC_N-1:0] srcReq;
  logic [`IPRR_SRC_N-1:0] evt;
  iprr_src_s [`IPRR_SRC_N-1:0] srcLevel;
  logic [3:0] winIdx;
  logic [3:0] a;
  int n_mismatch;
  int comparisons;
  int pos[15] = '{14, 12, 8, 6, 4, 2, 0, 14, 12, 10, 8, 6, 4, 2, 0};

  iprr_top dut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .srcIrq(srcIrq), .srcLevel(srcLevel),
    .srcReq(srcReq));
  iprr_arb_model arb (.clk(clk), .evt(evt), .srcIrq(srcIrq), .srcLevel(srcLevel), .srcReq(srcReq),
    .winIdx(winIdx));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chkSrc(input iprr_src_s got, input iprr_src_s exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Source i holds code c, every other source disabled
  task automatic chkAll(input int i, input int c);
    for (int j = 0; j < 15; j++) begin
      chkSrc(srcLevel[j], (j == i && c != 0) ? {1'b1, 2'(c - 1)} : 3'h0);
    end
    chkWord({1'b0, srcReq}, (c != 0) ? (16'h0001 << i) : 16'h0000);
  endtask

  task automatic wrReg(input logic [3:0] ad, input iprr_word_t d);
    @(posedge clk);
    bus.addr <= ad;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    bus.rd <= 1'b0;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rdReg(input logic [3:0] ad, input iprr_word_t exp);
    @(posedge clk);
    bus.addr <= ad;
    bus.rd <= 1'b1;
    bus.wr <= 1'b0;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    chkWord(rdata, exp);
  endtask

  // Write, then read the same place in the very next cycle
  task automatic wrRd(input logic [3:0] ad, input iprr_word_t d, input iprr_word_t exp);
    @(posedge clk);
    bus.addr <= ad;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    bus.rd <= 1'b0;
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    chkWord(rdata, exp);
  endtask

  task automatic idle();
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    @(negedge clk);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    bus = '0;
    evt = '1;
    n_mismatch = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chkAll(0, 0);
    rdReg(`IPRR_OFS_SER_TMR, 16'h0000);
    rdReg(`IPRR_OFS_PWM_ADC, 16'h0000);
    // Codes 1 to 3 of every field, read back the cycle after the write
    for (int i = 0; i < 15; i++) begin
      a = (i < 7) ? `IPRR_OFS_SER_TMR : `IPRR_OFS_PWM_ADC;
      for (int c = 1; c < 4; c++) begin
        wrRd(a, 16'(c) << pos[i], 16'(c) << pos[i]);
        chkAll(i, c);
      end
      wrReg(a, 16'h0000);
      chkAll(i, 0);
    end
    wrRd(`IPRR_OFS_SER_TMR, 16'hFFFF, 16'hF3FF);
    wrRd(`IPRR_OFS_PWM_ADC, 16'hFFFF, 16'hFFFF);
    for (int j = 0; j < 15; j++) begin
      chkSrc(srcLevel[j], 3'h6);
    end
    wrReg(`IPRR_OFS_PWM_ADC, 16'h0000);
    wrReg(`IPRR_OFS_SER_TMR, 16'h4003);
    chkWord({12'h000, winIdx}, 16'h0006);
    // Only source 0 keeps its event; the enabled timer source must drop
    @(posedge clk);
    evt <= 15'h0001;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chkWord({1'b0, srcReq}, 16'h0001);
    chkWord({12'h000, winIdx}, 16'h0000);
    // Unmapped place ignores writes and reads zero
    wrReg(4'h7, 16'hFFFF);
    rdReg(4'h7, 16'h0000);
    rdReg(`IPRR_OFS_SER_TMR, 16'h4003);
    idle();
    chkWord(rdata, 16'h0000);
    // Second reset in mid-run, both registers loaded first
    wrReg(`IPRR_OFS_PWM_ADC, 16'h5555);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chkAll(0, 0);
    rdReg(`IPRR_OFS_SER_TMR, 16'h0000);
    rdReg(`IPRR_OFS_PWM_ADC, 16'h0000);
    idle();
    print_verdict();
  end
endmodule
